// ### pkg/swbus_pkg.sv
// constants and types for the single-wire bus transceiver control block
package swbus_pkg;

    // mode pair {high, low}
    typedef enum logic [1:0] {
        MODE_SLEEP = 2'h0,
        MODE_HIGH_SPEED = 2'h1,
        MODE_WAKEUP = 2'h2,
        MODE_NORMAL = 2'h3
    } mode_t;

    // gray along sleep -> standby -> active
    typedef enum logic [1:0] {
        ST_SLEEP = 2'h0,
        ST_STANDBY = 2'h1,
        ST_ACTIVE = 2'h3
    } power_state_t;

    // timing
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned TX_TIMEOUT_MS = 17;
    localparam int unsigned STANDBY_TIMEOUT_MS = 250;
    localparam int unsigned WAKE_FILTER_US = 10;
    localparam int unsigned RX_BLANK_NS = 500;
    localparam int unsigned TX_TIMEOUT_CYC = TX_TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int unsigned STANDBY_TIMEOUT_CYC = STANDBY_TIMEOUT_MS * CLK_MHZ * 1000;
    localparam int unsigned WAKE_FILTER_CYC = WAKE_FILTER_US * CLK_MHZ;
    localparam int unsigned RX_BLANK_CYC = (RX_BLANK_NS * CLK_MHZ + 999) / 1000;

    // register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EVENTS = 8'h08;

    // control fields
    localparam int CTRL_TIMEOUT_EN_BIT = 0;
    localparam int CTRL_BLANK_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;

    // status fields
    localparam int STATUS_MODE_LSB = 0;
    localparam int STATUS_STATE_LSB = 2;
    localparam int STATUS_TIMEOUT_BIT = 4;
    localparam int STATUS_BLANK_BIT = 5;
    localparam int STATUS_LOAD_BIT = 6;

    // event fields, write one to clear
    localparam int EVT_WAKE_BIT = 0;
    localparam int EVT_TIMEOUT_BIT = 1;
    localparam logic [1:0] EVT_RESET = 2'h0;

endpackage

// ### design/swbus_ctrl.sv
// control logic of the single-wire bus transceiver with an apb register slave
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module swbus_ctrl #(
    parameter int unsigned TX_TIMEOUT_CYCLES = swbus_pkg::TX_TIMEOUT_CYC,
    parameter int unsigned STANDBY_CYCLES = swbus_pkg::STANDBY_TIMEOUT_CYC,
    parameter int unsigned WAKE_FILTER_CYCLES = swbus_pkg::WAKE_FILTER_CYC,
    parameter int unsigned BLANK_CYCLES = swbus_pkg::RX_BLANK_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host side pins, each input with a driven flag for the internal pulls
    input wire logic txd,
    input wire logic txd_driven,
    input wire logic mode_select_low,
    input wire logic mode_select_low_driven,
    input wire logic mode_select_high,
    input wire logic mode_select_high_driven,
    output logic rxd,
    output logic rxd_oe,
    // bus line sense from the analog receivers
    input wire logic bus_line_dominant,
    input wire logic bus_line_high_voltage,
    // bus line driver control
    output logic bus_line_drive,
    output logic high_voltage_wakeup,
    output logic slope_shaping_en,
    // supply and ground monitors
    input wire logic supply_low,
    input wire logic loss_of_ground,
    output logic load_switch_closed
);
    import swbus_pkg::*;

    typedef struct packed {
        logic [1:0] mode_meta;
        logic [1:0] mode_sync;
        power_state_t pstate;
        logic [31:0] sleep_tmr;
        logic [31:0] tout_cnt;
        logic tout;
        logic txd_prev;
        logic [15:0] blank_cnt;
        logic [1:0] ctrl;
        logic [1:0] events;
        logic rxd;
        logic rxd_oe;
        logic drive;
        logic hv;
        logic slope;
        logic load_closed;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_t;

    localparam state_t STATE_RESET = '{
        mode_meta: 2'h0,
        mode_sync: 2'h0,
        pstate: ST_SLEEP,
        sleep_tmr: 32'h0,
        tout_cnt: 32'h0,
        tout: 1'b0,
        txd_prev: 1'b1,
        blank_cnt: 16'h0,
        ctrl: CTRL_RESET,
        events: EVT_RESET,
        rxd: 1'b1,
        rxd_oe: 1'b0,
        drive: 1'b0,
        hv: 1'b0,
        slope: 1'b1,
        load_closed: 1'b1,
        prdata: 32'h0,
        pready: 1'b0,
        pslverr: 1'b0
    };

    function automatic mode_t decode_mode(input logic [1:0] pins);
        decode_mode = mode_t'(pins);
    endfunction

    function automatic logic addr_mapped(input logic [7:0] a);
        addr_mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_EVENTS);
    endfunction

    state_t cur;
    state_t next_state;

    logic txd_eff;
    logic [1:0] mode_pins;
    mode_t mode;
    logic bus_dom;
    logic txd_rise;
    logic blanking;
    logic wr_access;
    logic setup;
    logic set_wake;
    logic set_tout;

    always_comb begin
        next_state = cur;
        // undriven txd reads high, undriven mode pins read low
        txd_eff = txd_driven ? txd : 1'b1;
        mode_pins[0] = mode_select_low_driven & mode_select_low;
        mode_pins[1] = mode_select_high_driven & mode_select_high;
        mode = decode_mode(cur.mode_sync);
        bus_dom = bus_line_dominant | bus_line_high_voltage;
        txd_rise = txd_eff & ~cur.txd_prev;
        blanking = cur.blank_cnt != 16'h0;
        set_wake = 1'b0;
        set_tout = 1'b0;

        // mode pins pass two flops before anything decodes them
        next_state.mode_meta = mode_pins;
        next_state.mode_sync = cur.mode_meta;
        next_state.txd_prev = txd_eff;

        // power state
        case (cur.pstate)
            ST_SLEEP: begin
                if (mode != MODE_SLEEP) begin
                    next_state.pstate = ST_ACTIVE;
                    next_state.sleep_tmr = 32'h0;
                end else if (bus_line_high_voltage) begin
                    // only the raised level counts; normal traffic is ignored
                    if (cur.sleep_tmr + 32'h1 >= WAKE_FILTER_CYCLES) begin
                        next_state.pstate = ST_STANDBY;
                        next_state.sleep_tmr = 32'h0;
                        set_wake = 1'b1;
                    end else begin
                        next_state.sleep_tmr = cur.sleep_tmr + 32'h1;
                    end
                end else begin
                    next_state.sleep_tmr = 32'h0;
                end
            end
            ST_STANDBY: begin
                if (mode != MODE_SLEEP) begin
                    next_state.pstate = ST_ACTIVE;
                    next_state.sleep_tmr = 32'h0;
                end else if (cur.sleep_tmr + 32'h1 >= STANDBY_CYCLES) begin
                    next_state.pstate = ST_SLEEP;
                    next_state.sleep_tmr = 32'h0;
                end else begin
                    next_state.sleep_tmr = cur.sleep_tmr + 32'h1;
                end
            end
            ST_ACTIVE: begin
                if (mode == MODE_SLEEP) begin
                    next_state.pstate = ST_SLEEP;
                end
            end
            default: begin
                next_state.pstate = ST_SLEEP;
                next_state.sleep_tmr = 32'h0;
            end
        endcase

        // stuck dominant timeout; cleared by the next txd rising edge
        if (txd_rise) begin
            next_state.tout = 1'b0;
            next_state.tout_cnt = 32'h0;
        end else if (cur.pstate == ST_ACTIVE && !txd_eff && !cur.tout
                     && cur.ctrl[CTRL_TIMEOUT_EN_BIT]) begin
            // same limit in normal, high-speed and wake-up modes
            if (cur.tout_cnt + 32'h1 >= TX_TIMEOUT_CYCLES) begin
                next_state.tout = 1'b1;
                set_tout = 1'b1;
            end else begin
                next_state.tout_cnt = cur.tout_cnt + 32'h1;
            end
        end else if (txd_eff) begin
            next_state.tout_cnt = 32'h0;
        end

        // bus driver; standby counts as asleep for transmit
        next_state.drive = (next_state.pstate == ST_ACTIVE)
                           && !txd_eff && !next_state.tout;
        next_state.hv = (mode == MODE_WAKEUP) && !supply_low;
        next_state.slope = (mode != MODE_HIGH_SPEED);

        // receive blanking after each txd rising edge
        if (txd_rise && cur.ctrl[CTRL_BLANK_EN_BIT]) begin
            next_state.blank_cnt = 16'(BLANK_CYCLES);
        end else if (blanking) begin
            next_state.blank_cnt = cur.blank_cnt - 16'h1;
        end

        // receive output
        case (next_state.pstate)
            ST_ACTIVE: begin
                next_state.rxd_oe = 1'b1;
                // ringing during blanking is hidden by holding the last level
                if (!blanking) begin
                    next_state.rxd = ~bus_dom;
                end
            end
            ST_STANDBY: begin
                // wake interrupt held low until the host acts or sleep returns
                next_state.rxd_oe = 1'b1;
                next_state.rxd = 1'b0;
            end
            default: begin
                next_state.rxd_oe = 1'b0;
                next_state.rxd = 1'b1;
            end
        endcase

        next_state.load_closed = ~loss_of_ground;

        // apb: no wait states, answer in the first access cycle
        setup = psel & ~penable;
        wr_access = psel & penable & pwrite & cur.pready;
        next_state.pready = setup;
        next_state.pslverr = setup & ~addr_mapped(paddr);
        next_state.prdata = 32'h0;
        if (setup && !pwrite) begin
            case (paddr)
                ADDR_CTRL: next_state.prdata[1:0] = cur.ctrl;
                ADDR_STATUS: begin
                    next_state.prdata[STATUS_MODE_LSB +: 2] = mode;
                    next_state.prdata[STATUS_STATE_LSB +: 2] = cur.pstate;
                    next_state.prdata[STATUS_TIMEOUT_BIT] = cur.tout;
                    next_state.prdata[STATUS_BLANK_BIT] = blanking;
                    next_state.prdata[STATUS_LOAD_BIT] = cur.load_closed;
                end
                ADDR_EVENTS: next_state.prdata[1:0] = cur.events;
                default: next_state.prdata = 32'h0;
            endcase
        end
        if (wr_access && paddr == ADDR_CTRL) begin
            next_state.ctrl = pwdata[1:0];
        end
        // set wins over a same-cycle clear
        if (wr_access && paddr == ADDR_EVENTS) begin
            next_state.events = cur.events & ~pwdata[1:0];
        end
        if (set_wake) begin
            next_state.events[EVT_WAKE_BIT] = 1'b1;
        end
        if (set_tout) begin
            next_state.events[EVT_TIMEOUT_BIT] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= STATE_RESET;
        end else begin
            cur <= next_state;
        end
    end

    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign rxd = cur.rxd;
    assign rxd_oe = cur.rxd_oe;
    assign bus_line_drive = cur.drive;
    assign high_voltage_wakeup = cur.hv;
    assign slope_shaping_en = cur.slope;
    assign load_switch_closed = cur.load_closed;

endmodule // swbus_ctrl

// ### sim/swbus_ctrl_checker.sv
// assertion checker for the single-wire bus control block
`timescale 1ns/100ps
module swbus_ctrl_checker #(
    parameter int unsigned TX_TIMEOUT_CYCLES = 50
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // host pins
    input wire logic txd,
    input wire logic txd_driven,
    input wire logic mode_select_low,
    input wire logic mode_select_low_driven,
    input wire logic mode_select_high,
    input wire logic mode_select_high_driven,
    input wire logic rxd,
    input wire logic rxd_oe,
    // bus and monitors
    input wire logic bus_line_high_voltage,
    input wire logic bus_line_drive,
    input wire logic high_voltage_wakeup,
    input wire logic slope_shaping_en,
    input wire logic supply_low,
    input wire logic loss_of_ground,
    input wire logic load_switch_closed
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // floating mode pins count as low
    wire ml = mode_select_low_driven && mode_select_low;
    wire mh = mode_select_high_driven && mode_select_high;
    logic [31:0] run;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run <= 32'h0;
        end else begin
            run <= bus_line_drive ? run + 32'h1 : 32'h0;
        end
    end
    // count matches the short wake filter used in the bench
    sequence s_wake;
        (!rxd_oe && bus_line_high_voltage) [*8];
    endsequence
    sequence s_asleep;
        (!rxd_oe && !bus_line_high_voltage && !ml && !mh) [*4];
    endsequence
    AST_LOAD_GROUND: assert property (1'b1 |=> load_switch_closed != $past(loss_of_ground))
        else $error("load switch wrong");
    AST_SLEEP_NO_DRIVE: assert property (!rxd_oe |-> !bus_line_drive)
        else $error("drive while asleep");
    AST_DRIVE_CAUSE: assert property (bus_line_drive |-> $past(txd_driven) && !$past(txd))
        else $error("drive without low transmit");
    AST_TX_TIMEOUT: assert property (run <= TX_TIMEOUT_CYCLES + 1)
        else $error("drive past timeout");
    AST_HV_SUPPLY: assert property (high_voltage_wakeup |-> !$past(supply_low))
        else $error("raised level on low supply");
    AST_WAKE_IRQ: assert property (s_wake |-> ##[1:3] (rxd_oe && !rxd))
        else $error("no wake interrupt");
    AST_SLEEP_QUIET: assert property (s_asleep |=> !rxd_oe)
        else $error("woke without cause");
    AST_SLOPE_OFF: assert property ((ml && !mh) [*4] |-> !slope_shaping_en)
        else $error("shaping on in high speed");
    AST_SLOPE_ON: assert property ((!ml || mh) [*4] |-> slope_shaping_en)
        else $error("shaping off");
endmodule // swbus_ctrl_checker

// ### sim/swbus_host_model.sv
// host-side model: drives or floats the transmit and mode pins
`timescale 1ns/100ps
module swbus_host_model (
    // clock
    input wire logic pclk,
    // transmit pin
    output logic txd,
    output logic txd_driven,
    // mode pins
    output logic mode_select_low,
    output logic mode_select_low_driven,
    output logic mode_select_high,
    output logic mode_select_high_driven
);
    initial begin
        {txd, txd_driven} = 2'h3;
        {mode_select_high, mode_select_low} = 2'h0;
        {mode_select_high_driven, mode_select_low_driven} = 2'h3;
    end
    // a released pin wanders, so only the internal pulls may decide
    always @(negedge pclk) begin
        if (!txd_driven) txd <= ~txd;
        if (!mode_select_low_driven) mode_select_low <= ~mode_select_low;
        if (!mode_select_high_driven) mode_select_high <= ~mode_select_high;
    end
    task automatic set_tx(input logic level, input logic drv);
        txd <= level;
        txd_driven <= drv;
    endtask
    task automatic set_mode(input logic [1:0] m, input logic drv);
        {mode_select_high, mode_select_low} <= m;
        {mode_select_high_driven, mode_select_low_driven} <= {drv, drv};
    endtask
endmodule // swbus_host_model

// ### sim/test_single_wire_bus_transceiver_ctrl.sv
// self-checking bench for the single-wire bus control block
`timescale 1ns/100ps
module test_single_wire_bus_transceiver_ctrl;
    import swbus_pkg::*;
    // short counts keep the run brief
    localparam int unsigned TXC = 50;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rxd, rxd_oe, bus_line_drive, high_voltage_wakeup;
    logic slope_shaping_en, load_switch_closed, txd, txd_driven, mode_select_low;
    logic mode_select_low_driven, mode_select_high, mode_select_high_driven;
    logic bus_line_dominant = 1'b0, bus_line_high_voltage = 1'b0;
    logic supply_low = 1'b0, loss_of_ground = 1'b0;
    logic [1:0] q[$];
    int num_errors = 0, n_tests = 0, seed = 57351;
    always #2 pclk = ~pclk;
    swbus_ctrl #(.TX_TIMEOUT_CYCLES(TXC), .STANDBY_CYCLES(100), .WAKE_FILTER_CYCLES(8),
        .BLANK_CYCLES(4)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .txd, .txd_driven, .mode_select_low, .mode_select_low_driven,
        .mode_select_high, .mode_select_high_driven, .rxd, .rxd_oe, .bus_line_dominant,
        .bus_line_high_voltage, .bus_line_drive, .high_voltage_wakeup, .slope_shaping_en,
        .supply_low, .loss_of_ground, .load_switch_closed);
    swbus_host_model u_host (.pclk, .txd, .txd_driven, .mode_select_low,
        .mode_select_low_driven, .mode_select_high, .mode_select_high_driven);
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        // request stands until pready is seen high at an edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            $display("unexpected at %0t: no apb answer", $time);
        end
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: pins %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
        input logic exp_err);
        apb(1'b0, a, 32'h0);
        n_tests++;
        if ((rd & m) !== exp || err !== exp_err) begin
            num_errors++;
            $display("unexpected at %0t: reg %h read %h err %b", $time, a, rd, err);
        end
    endtask
    task automatic give_verdict;
        $display("errors %0d comparisons %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        tick(5);
        #1;
        chk_pin(8'({rxd, rxd_oe, bus_line_drive, slope_shaping_en, load_switch_closed}), 8'h13);
        tick(1);
        presetn <= 1'b1;
        chk_reg(ADDR_CTRL, 32'hFFFFFFFF, {30'h0, CTRL_RESET}, 1'b0);
        apb(1'b1, ADDR_CTRL, 32'hFFFFFFFF);
        apb(1'b1, ADDR_STATUS, 32'h0);
        chk_reg(ADDR_CTRL, 32'hFFFFFFFF, 32'h3, 1'b0);
        chk_reg(ADDR_STATUS, 32'hFFFFFFFF, 32'h40, 1'b0);
        chk_reg(ADDR_EVENTS, 32'hFFFFFFFF, 32'h0, 1'b0);
        chk_reg(8'h0C, 32'hFFFFFFFF, 32'h0, 1'b1);
        // normal-level traffic and a short raised burst must not wake it
        u_host.set_tx(1'b0, 1'b1);
        for (int i = 0; i < 24; i++) begin
            tick(1);
            bus_line_dominant <= 1'($random(seed));
            bus_line_high_voltage <= (i < 5);
            #1;
            chk_pin(8'({rxd_oe, bus_line_drive}), 8'h0);
        end
        tick(1);
        u_host.set_tx(1'b1, 1'b1);
        bus_line_dominant <= 1'b0;
        bus_line_high_voltage <= 1'b1;
        tick(10);
        bus_line_high_voltage <= 1'b0;
        tick(2);
        #1;
        chk_pin(8'({rxd_oe, rxd}), 8'h2);
        chk_reg(ADDR_STATUS, 32'hF, 32'h4, 1'b0);
        chk_reg(ADDR_EVENTS, 32'h1, 32'h1, 1'b0);
        apb(1'b1, ADDR_EVENTS, 32'h1);
        chk_reg(ADDR_EVENTS, 32'h3, 32'h0, 1'b0);
        tick(70);
        #1;
        chk_pin(8'(rxd_oe), 8'h1);
        tick(30);
        #1;
        chk_pin(8'(rxd_oe), 8'h0);
        // every mode, with and without low supply; pattern four floats the pins
        for (int i = 0; i < 8; i++) begin
            tick(1);
            u_host.set_mode(i[1:0], i != 4);
            supply_low <= i[2];
            tick(5);
            u_host.set_tx(1'b0, 1'b1);
            tick(2);
            #1;
            chk_pin(8'({rxd_oe, bus_line_drive, high_voltage_wakeup, slope_shaping_en}),
                8'({i[1:0] != 0, i[1:0] != 0, i == 2, i[1:0] != 1}));
            tick(1);
            u_host.set_tx(1'b1, 1'b1);
            chk_reg(ADDR_STATUS, 32'hF, {28'h0, (i[1:0] != 0) ? 2'h3 : 2'h0, i[1:0]}, 1'b0);
        end
        tick(1);
        u_host.set_tx(1'b0, 1'b1);
        tick(TXC - 10);
        #1;
        chk_pin(8'(bus_line_drive), 8'h1);
        tick(12);
        #1;
        chk_pin(8'(bus_line_drive), 8'h0);
        chk_reg(ADDR_STATUS, 32'h10, 32'h10, 1'b0);
        chk_reg(ADDR_EVENTS, 32'h3, 32'h2, 1'b0);
        tick(1);
        u_host.set_tx(1'b1, 1'b0);
        tick(3);
        u_host.set_tx(1'b0, 1'b1);
        tick(2);
        #1;
        chk_pin(8'(bus_line_drive), 8'h1);
        tick(1);
        u_host.set_tx(1'b1, 1'b1);
        // dominant bus inside the blanking window must not reach rxd
        tick(1);
        bus_line_dominant <= 1'b1;
        tick(2);
        #1;
        chk_pin(8'(rxd), 8'h1);
        tick(5);
        #1;
        chk_pin(8'(rxd), 8'h0);
        // past the receive blanking window, then random bus and ground
        for (int i = 0; i < 40; i++) begin
            bus_line_dominant <= 1'($random(seed));
            bus_line_high_voltage <= 1'($random(seed));
            loss_of_ground <= 1'($random(seed));
            #1;
            if (q.size() > 0) chk_pin(8'({rxd, load_switch_closed}), 8'(q.pop_front()));
            q.push_back({!(bus_line_dominant || bus_line_high_voltage), !loss_of_ground});
            tick(1);
        end
        give_verdict();
    end
    // about thirteen times the expected run length
    initial begin
        #20000;
        num_errors++;
        give_verdict();
    end
endmodule // test_single_wire_bus_transceiver_ctrl
bind swbus_ctrl swbus_ctrl_checker #(.TX_TIMEOUT_CYCLES(TX_TIMEOUT_CYCLES)) u_chk (.pclk,
    .presetn, .txd, .txd_driven, .mode_select_low, .mode_select_low_driven, .mode_select_high,
    .mode_select_high_driven, .rxd, .rxd_oe, .bus_line_high_voltage, .bus_line_drive,
    .high_voltage_wakeup, .slope_shaping_en, .supply_low, .loss_of_ground, .load_switch_closed);
